// ===== design/pin_mux_pkg.sv
package pin_mux_pkg;

   // ******************************************************
   // register map (index; byte address is four times it)
   // ******************************************************
   localparam logic [7:0] CTRL_INDEX   = 8'h16;
   localparam logic [7:0] STATUS_INDEX = 8'h20;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam int         NUM_RX       = 4;

   // ******************************************************
   // field codes
   // ******************************************************
   typedef enum logic [2:0] {
      SRC_RX0 = 3'h0,
      SRC_RX1 = 3'h1,
      SRC_RX2 = 3'h2,
      SRC_RX3 = 3'h3,
      SRC_DEV = 3'h4,
      SRC_TX  = 3'h6
   } src_type;

   localparam logic [2:0] RX_LOCK      = 3'h4;
   localparam logic [2:0] RX_PASS      = 3'h5;
   localparam logic [2:0] RX_FV        = 3'h6;
   localparam logic [2:0] RX_LV        = 3'h7;
   localparam logic [2:0] DEV_VALUE    = 3'h0;
   localparam logic [2:0] DEV_LOCK_OR  = 3'h1;
   localparam logic [2:0] DEV_LOCK_AND = 3'h2;
   localparam logic [2:0] DEV_PASS_AND = 3'h3;
   localparam logic [2:0] DEV_FSYNC    = 3'h4;
   localparam logic [2:0] TX_PASS_AND  = 3'h0;
   localparam logic [2:0] TX_PASS_OR   = 3'h1;
   localparam logic [2:0] TX_FV        = 3'h2;
   localparam logic [2:0] TX_LV        = 3'h3;
   localparam logic [2:0] TX_SYNC      = 3'h4;
   localparam logic [2:0] TX_IRQ       = 3'h5;

   // ******************************************************
   // carriers
   // ******************************************************
   typedef struct packed {
      logic [2:0] sel;
      logic [2:0] src;
      logic       val;
      logic       en;
   } ctrl_type;

   typedef struct packed {
      logic [3:0] remote_pin;
      logic       lock;
      logic       pass;
      logic       fv;
      logic       lv;
   } rx_ind_type;

   typedef struct packed {
      logic fv;
      logic lv;
      logic synced;
      logic irq;
   } tx_ind_type;

endpackage

// ===== design/pin_six_mux.sv
// Behaviour
// - source field bits 4:2 picks rx port 0-3, device status or transmit port
// - rx source: select codes 000-011 drive forwarded remote pins 0-3
// - rx source: select 100-111 drive lock, pass, frame valid, line valid
// - device status: 001 ors, 010 ands lock of enabled rx ports
// - device status: 011 ands pass of enabled ports, 100 frame sync
// - device status 000 drives the local value bit 1, gated by enable bit 0
// - transmit source: 000 ands, 001 ors pass of enabled rx ports
// - control register at index 0x16 resets to all zero
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module pin_six_mux
(
   // clock and reset
   input  wire logic                                    i_clk,
   input  wire logic                                    i_rst,
   // wishbone classic slave
   input  wire logic                                    i_wb_cyc,
   input  wire logic                                    i_wb_stb,
   input  wire logic                                    i_wb_we,
   input  wire logic [9:0]                              i_wb_adr,
   input  wire logic [3:0]                              i_wb_sel,
   input  wire logic [31:0]                             i_wb_dat,
   output logic      [31:0]                             o_wb_dat,
   output logic                                         o_wb_ack,
   // receive port and device indications
   input  wire pin_mux_pkg::rx_ind_type [3:0]           i_rx_ind,
   input  wire logic [3:0]                              i_rx_enabled,
   input  wire logic                                    i_frame_sync_pulse,
   // transmit port indications
   input  wire pin_mux_pkg::tx_ind_type                 i_tx_ind,
   // pin drive
   output logic                                         o_pin_out,
   output logic                                         o_pin_oe
);

   // ******************************************************
   // helpers
   // ******************************************************
   // an empty mask gives 1 for the and form, 0 for the or form
   function automatic logic masked_and(input logic [3:0] v, input logic [3:0] m);
      masked_and = &(v | ~m);
   endfunction

   function automatic logic masked_or(input logic [3:0] v, input logic [3:0] m);
      masked_or = |(v & m);
   endfunction

   function automatic logic pick_rx(input pin_mux_pkg::rx_ind_type p, input logic [2:0] s);
      logic r;
      r = 1'b0;
      if (s[2] == 1'b0)
         r = p.remote_pin[s[1:0]];
      else if (s == pin_mux_pkg::RX_LOCK)
         r = p.lock;
      else if (s == pin_mux_pkg::RX_PASS)
         r = p.pass;
      else if (s == pin_mux_pkg::RX_FV)
         r = p.fv;
      else
         r = p.lv;
      pick_rx = r;
   endfunction

   // ******************************************************
   // bus slave
   // ******************************************************
   pin_mux_pkg::ctrl_type ctrl_q;
   logic                  ack_q;
   logic [31:0]           rdat_q;
   logic                  pin_q;
   logic                  oe_q;
   logic                  req;
   logic                  hit_ctrl;
   logic                  hit_status;
   logic                  mux_d;

   assign req        = i_wb_cyc && i_wb_stb && !ack_q;
   assign hit_ctrl   = i_wb_adr[9:2] == pin_mux_pkg::CTRL_INDEX;
   assign hit_status = i_wb_adr[9:2] == pin_mux_pkg::STATUS_INDEX;

   // one wait state: ack follows the request by one edge, then drops
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         ack_q <= 1'b0;
      else
         ack_q <= req;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         ctrl_q <= pin_mux_pkg::CTRL_RESET;
      else if (req && i_wb_we && hit_ctrl && i_wb_sel[0])
         ctrl_q <= i_wb_dat[7:0];
   end

   // read data is captured with the ack; unmapped offsets read zero
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         rdat_q <= 32'h0000_0000;
      else if (req && !i_wb_we)
      begin
         if (hit_ctrl)
            rdat_q <= {24'h00_0000, ctrl_q};
         else if (hit_status)
            rdat_q <= {30'h0000_0000, oe_q, pin_q};
         else
            rdat_q <= 32'h0000_0000;
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = rdat_q;

   // ******************************************************
   // source multiplexer
   // ******************************************************
   always_comb
   begin
      mux_d = 1'b0;
      if (ctrl_q.src[2] == 1'b0)
         mux_d = pick_rx(i_rx_ind[ctrl_q.src[1:0]], ctrl_q.sel);
      else if (ctrl_q.src == pin_mux_pkg::SRC_DEV)
      begin
         case (ctrl_q.sel)
            pin_mux_pkg::DEV_VALUE:    mux_d = ctrl_q.val;
            pin_mux_pkg::DEV_LOCK_OR:
               mux_d = masked_or({i_rx_ind[3].lock, i_rx_ind[2].lock,
                                  i_rx_ind[1].lock, i_rx_ind[0].lock}, i_rx_enabled);
            pin_mux_pkg::DEV_LOCK_AND:
               mux_d = masked_and({i_rx_ind[3].lock, i_rx_ind[2].lock,
                                   i_rx_ind[1].lock, i_rx_ind[0].lock}, i_rx_enabled);
            pin_mux_pkg::DEV_PASS_AND:
               mux_d = masked_and({i_rx_ind[3].pass, i_rx_ind[2].pass,
                                   i_rx_ind[1].pass, i_rx_ind[0].pass}, i_rx_enabled);
            pin_mux_pkg::DEV_FSYNC:    mux_d = i_frame_sync_pulse;
            default:                   mux_d = 1'b0;
         endcase
      end
      else if (ctrl_q.src == pin_mux_pkg::SRC_TX)
      begin
         case (ctrl_q.sel)
            pin_mux_pkg::TX_PASS_AND:
               mux_d = masked_and({i_rx_ind[3].pass, i_rx_ind[2].pass,
                                   i_rx_ind[1].pass, i_rx_ind[0].pass}, i_rx_enabled);
            pin_mux_pkg::TX_PASS_OR:
               mux_d = masked_or({i_rx_ind[3].pass, i_rx_ind[2].pass,
                                  i_rx_ind[1].pass, i_rx_ind[0].pass}, i_rx_enabled);
            pin_mux_pkg::TX_FV:        mux_d = i_tx_ind.fv;
            pin_mux_pkg::TX_LV:        mux_d = i_tx_ind.lv;
            pin_mux_pkg::TX_SYNC:      mux_d = i_tx_ind.synced;
            pin_mux_pkg::TX_IRQ:       mux_d = i_tx_ind.irq;
            default:                   mux_d = 1'b0;
         endcase
      end
      else
         mux_d = 1'b0;
   end

   // ******************************************************
   // pin drive
   // ******************************************************
   // registered so the pin never glitches while the mux inputs settle
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         pin_q <= 1'b0;
         oe_q  <= 1'b0;
      end
      else
      begin
         pin_q <= ctrl_q.en & mux_d;
         oe_q  <= ctrl_q.en;
      end
   end

   assign o_pin_out = pin_q;
   assign o_pin_oe  = oe_q;

   // ******************************************************
   // assertions
   // ******************************************************
   property p_reset_zero;
      @(posedge i_clk) $past(i_rst) |-> ctrl_q == 8'h00 && !o_pin_oe && !o_pin_out;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("control or pin not cleared by reset");

   property p_disabled_quiet;
      @(posedge i_clk) disable iff (i_rst)
         !ctrl_q.en |=> !o_pin_oe && !o_pin_out;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet)
      else $error("pin driven while output disabled");

   property p_write_takes;
      @(posedge i_clk) disable iff (i_rst)
         req && i_wb_we && hit_ctrl && i_wb_sel[0] |=> ctrl_q == $past(i_wb_dat[7:0]);
   endproperty
   a_write_takes: assert property (p_write_takes)
      else $error("control write not stored");

   property p_local_value;
      @(posedge i_clk) disable iff (i_rst)
         ctrl_q.en && ctrl_q.src == pin_mux_pkg::SRC_DEV && ctrl_q.sel == 3'h0
         |=> o_pin_oe && o_pin_out == $past(ctrl_q.val);
   endproperty
   a_local_value: assert property (p_local_value)
      else $error("local value not on pin");

   property p_rx_remote;
      @(posedge i_clk) disable iff (i_rst)
         ctrl_q.en && !ctrl_q.src[2] && !ctrl_q.sel[2]
         |=> o_pin_out == $past(i_rx_ind[ctrl_q.src[1:0]].remote_pin[ctrl_q.sel[1:0]]);
   endproperty
   a_rx_remote: assert property (p_rx_remote)
      else $error("remote pin not forwarded");

   property p_rx_lock;
      @(posedge i_clk) disable iff (i_rst)
         ctrl_q.en && !ctrl_q.src[2] && ctrl_q.sel == 3'h4
         |=> o_pin_out == $past(i_rx_ind[ctrl_q.src[1:0]].lock);
   endproperty
   a_rx_lock: assert property (p_rx_lock)
      else $error("rx lock not forwarded");

   property p_lock_or;
      @(posedge i_clk) disable iff (i_rst)
         ctrl_q.en && ctrl_q.src == 3'h4 && ctrl_q.sel == 3'h1
         |=> o_pin_out == $past(|({i_rx_ind[3].lock, i_rx_ind[2].lock,
                                   i_rx_ind[1].lock, i_rx_ind[0].lock} & i_rx_enabled));
   endproperty
   a_lock_or: assert property (p_lock_or)
      else $error("lock or wrong");

   property p_tx_irq;
      @(posedge i_clk) disable iff (i_rst)
         ctrl_q.en && ctrl_q.src == 3'h6 && ctrl_q.sel == 3'h5
         |=> o_pin_out == $past(i_tx_ind.irq);
   endproperty
   a_tx_irq: assert property (p_tx_irq)
      else $error("tx interrupt not forwarded");

   property p_tx_pass_and;
      @(posedge i_clk) disable iff (i_rst)
         ctrl_q.en && ctrl_q.src == 3'h6 && ctrl_q.sel == 3'h0
         |=> o_pin_out == $past(&({i_rx_ind[3].pass, i_rx_ind[2].pass,
                                   i_rx_ind[1].pass, i_rx_ind[0].pass} | ~i_rx_enabled));
   endproperty
   a_tx_pass_and: assert property (p_tx_pass_and)
      else $error("tx pass and wrong");

   property p_reserved_low;
      @(posedge i_clk) disable iff (i_rst)
         ctrl_q.src == 3'h5 || ctrl_q.src == 3'h7 ||
         (ctrl_q.src == 3'h4 && ctrl_q.sel > 3'h4) |=> !o_pin_out;
   endproperty
   a_reserved_low: assert property (p_reserved_low)
      else $error("reserved code drove pin high");

   property p_ack_pulse;
      @(posedge i_clk) disable iff (i_rst)
         i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack not a single cycle after request");

   property p_cov_fsync;
      @(posedge i_clk) disable iff (i_rst)
         ctrl_q.en && ctrl_q.src == 3'h4 && ctrl_q.sel == 3'h4 ##1 o_pin_out;
   endproperty
   c_cov_fsync: cover property (p_cov_fsync);

   property p_cov_rx_lv;
      @(posedge i_clk) disable iff (i_rst)
         ctrl_q.en && ctrl_q.src == 3'h3 && ctrl_q.sel == 3'h7 ##1 o_pin_out;
   endproperty
   c_cov_rx_lv: cover property (p_cov_rx_lv);

   property p_cov_tx_sync;
      @(posedge i_clk) disable iff (i_rst)
         ctrl_q.en && ctrl_q.src == 3'h6 && ctrl_q.sel == 3'h4 ##1 o_pin_out;
   endproperty
   c_cov_tx_sync: cover property (p_cov_tx_sync);

endmodule

// ===== sim/gpio_output_source_mux_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module gpio_output_source_mux_tb_top;
   // ****************************************
   // signals
   // ****************************************
   logic                              i_clk    = 1'b0;
   logic                              i_rst    = 1'b1;
   logic                              wb_cyc   = 1'b0;
   logic                              wb_stb   = 1'b0;
   logic                              wb_we    = 1'b0;
   logic [9:0]                        wb_adr   = 10'h000;
   logic [3:0]                        wb_sel   = 4'h0;
   logic [31:0]                       wb_wdat  = 32'h0000_0000;
   logic [31:0]                       wb_rdat;
   logic                              wb_ack;
   pin_mux_pkg::rx_ind_type [3:0]     rx_ind   = '0;
   logic [3:0]                        rx_en    = 4'h0;
   logic                              fsync    = 1'b0;
   pin_mux_pkg::tx_ind_type           tx_ind   = '0;
   logic                              pin_out;
   logic                              pin_oe;
   logic                              pin_level;
   logic [31:0]                       rdat;
   int                                fail_count = 0;
   int                                n_checks   = 0;
   logic [31:0]                       rxp [4] = '{32'h5ac3_96e1, 32'ha53c_691e,
                                                  32'hff00_0ff0, 32'h0f0f_f0f0};
   logic [3:0]                        enp [4] = '{4'hb, 4'h4, 4'hf, 4'h0};
   logic [3:0]                        txp [4] = '{4'ha, 4'h5, 4'h3, 4'hc};

   always #4 i_clk = ~i_clk;

   pin_six_mux u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
      .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat),
      .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .i_rx_ind(rx_ind), .i_rx_enabled(rx_en),
      .i_frame_sync_pulse(fsync), .i_tx_ind(tx_ind), .o_pin_out(pin_out), .o_pin_oe(pin_oe));

   pin_board_reader u_board (.i_clk(i_clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
      .o_level(pin_level));

   // ****************************************
   // bus and closing tasks
   // ****************************************
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      n = 0;
      @(posedge i_clk);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= we;
      wb_adr  <= a;
      wb_wdat <= d;
      wb_sel  <= s;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         fail_count++;
         $display("mismatch at %0t: no bus answer", $time);
         end_sim();
      end
      rdat = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   // ****************************************
   // expected pin level while enabled
   // ****************************************
   function automatic logic exp_pin(input logic [7:0] c);
      logic [2:0] s;
      logic [3:0] lk;
      logic [3:0] ps;
      s = c[7:5];
      for (int i = 0; i < 4; i++)
      begin
         lk[i] = rx_ind[i].lock;
         ps[i] = rx_ind[i].pass;
      end
      case (c[4:2])
         3'h0, 3'h1, 3'h2, 3'h3: return s[2] ? rx_ind[c[3:2]][3'h7 - s]
                                             : rx_ind[c[3:2]].remote_pin[s[1:0]];
         3'h4:
            case (s)
               3'h0: return c[1];
               3'h1: return |(lk & rx_en);
               3'h2: return &(lk | ~rx_en);
               3'h3: return &(ps | ~rx_en);
               3'h4: return fsync;
               default: return 1'b0;
            endcase
         3'h6:
            case (s)
               3'h0: return &(ps | ~rx_en);
               3'h1: return |(ps & rx_en);
               3'h2: return tx_ind.fv;
               3'h3: return tx_ind.lv;
               3'h4: return tx_ind.synced;
               3'h5: return tx_ind.irq;
               default: return 1'b0;
            endcase
         default: return 1'b0;
      endcase
   endfunction

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      wb(1'b0, 10'h058, 32'h0, 4'hf);
      `CHK(rdat, 32'h0000_0000)
      `CHK({pin_oe, pin_out}, 2'b00)
      // unmapped place and a write with lane 0 disabled both leave control alone
      wb(1'b1, 10'h084, 32'hff, 4'hf);
      wb(1'b0, 10'h084, 32'h0, 4'hf);
      `CHK(rdat, 32'h0000_0000)
      wb(1'b1, 10'h058, 32'hff, 4'he);
      wb(1'b0, 10'h058, 32'h0, 4'hf);
      `CHK(rdat, 32'h0000_0000)
      for (int p = 0; p < 4; p++)
      begin
         @(posedge i_clk);
         rx_ind <= rxp[p];
         rx_en  <= enp[p];
         tx_ind <= txp[p];
         fsync  <= p[0];
         for (int v = 0; v < 256; v++)
         begin
            wb(1'b1, 10'h058, {24'h0, v[7:0]}, 4'h1);
            wb(1'b0, 10'h058, 32'h0, 4'hf);
            `CHK(rdat, {24'h0, v[7:0]})
            repeat (2) @(posedge i_clk);
            `CHK(pin_oe, v[0])
            if (v[0])
               `CHK(pin_level, exp_pin(v[7:0]))
            else
               `CHK(pin_out, 1'b0)
         end
      end
      // second reset in mid-run clears a non-zero control value
      @(posedge i_clk);
      i_rst <= 1'b1;
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      wb(1'b0, 10'h058, 32'h0, 4'hf);
      `CHK(rdat, 32'h0000_0000)
      `CHK(pin_oe, 1'b0)
      end_sim();
   end
endmodule

// ===== sim/pin_board_reader.sv
`timescale 1ns/1ps
// ****************************************
// board side reader of the output pin
// ****************************************
module pin_board_reader
(
   // clock
   input  wire logic i_clk,
   // pin from the device
   input  wire logic i_pin_out,
   input  wire logic i_pin_oe,
   // level seen on the board
   output logic      o_level
);
   logic last_q = 1'b0;

   always @(posedge i_clk)
   begin
      if (i_pin_oe)
         last_q <= i_pin_out;
   end

   // no pull on the trace: a released pin shows the opposite of its last level,
   // so a stale value can never pass for a driven one
   assign o_level = i_pin_oe ? i_pin_out : ~last_q;
endmodule
